// ==== design/gtc_pkg.sv ====
/*
  Package for the gated 16-bit timer/counter: register offsets, field
  positions, reset values, source and gate encodings, carrier structs.
  Assumes a 32-bit classic Wishbone master and a 50 MHz system clock.
*/
package gtc_pkg;
  // ****************************************
  // Register map (byte addresses)
  // ****************************************
  localparam logic [7:0] GTC_OFS_COUNT_LOW  = 8'h00;
  localparam logic [7:0] GTC_OFS_COUNT_HIGH = 8'h04;
  localparam logic [7:0] GTC_OFS_CTRL       = 8'h08;
  localparam logic [7:0] GTC_OFS_GATE       = 8'h0c;
  localparam logic [7:0] GTC_OFS_STATUS     = 8'h10;
  localparam int GTC_ADDR_W = 8;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int GTC_CTRL_ON_BIT   = 0;
  localparam int GTC_CTRL_SYNC_BIT = 2;
  localparam int GTC_CTRL_OSC_BIT  = 3;
  localparam int GTC_CTRL_PS_LSB   = 4;
  localparam int GTC_CTRL_CS_LSB   = 6;
  localparam int GTC_GATE_SS_LSB   = 0;
  localparam int GTC_GATE_POL_BIT  = 6;
  localparam int GTC_GATE_EN_BIT   = 7;
  localparam int GTC_STAT_OVF_BIT  = 0;
  localparam int GTC_STAT_OSC_BIT  = 1;

  // ****************************************
  // Reset values and counts
  // ****************************************
  localparam logic [15:0] GTC_COUNT_RST   = 16'h0000;
  localparam logic [1:0]  GTC_INSTR_DIV_M = 2'h3;
  localparam int          GTC_SYNC_DEPTH  = 3;

  typedef enum logic [1:0] {
    GTC_CS_INSTR = 2'b00,
    GTC_CS_SYS   = 2'b01,
    GTC_CS_EXT   = 2'b10,
    GTC_CS_CAP   = 2'b11
  } gtc_clk_sel_t;

  typedef enum logic [1:0] {
    GTC_GS_PIN  = 2'b00,
    GTC_GS_OVF  = 2'b01,
    GTC_GS_CMP1 = 2'b10,
    GTC_GS_CMP2 = 2'b11
  } gtc_gate_sel_t;

  typedef struct packed {
    gtc_clk_sel_t clock_select;
    logic [1:0]   prescale_select;
    logic         crystal_osc_enable;
    logic         sync_disable;
    logic         spare_bit;
    logic         counter_on;
  } gtc_ctrl_t;

  typedef struct packed {
    logic          gate_control_enable;
    logic          gate_polarity;
    gtc_gate_sel_t gate_source_select;
  } gtc_gate_t;

  localparam gtc_ctrl_t GTC_CTRL_RST = '{GTC_CS_INSTR, 2'h0, 1'b0, 1'b0, 1'b0, 1'b0};
  localparam gtc_gate_t GTC_GATE_RST = '{1'b0, 1'b0, GTC_GS_PIN};
endpackage : gtc_pkg

// ==== design/gtc_timer.sv ====
/*
  Gated 16-bit up timer/counter with Wishbone register access.
  Assumes pin inputs are asynchronous, comparator and companion overflow
  inputs come from logic on clk_i, and sleep_i is driven on clk_i.
*/
// Operation
// - 16-bit up counter with high and low bytes; writes load the byte
// - Off when on bit is 0; gate enable picks free or gated count
// - Clock select plus oscillator enable picks one of five count clocks
// - System clock source advances four counts per instruction cycle
// - External pin or cap oscillator counts on rising edge, sync or async
// - External source needs a falling edge before first counted rising edge
// - Prescaler divides by 1, 2, 4 or 8 and is hidden from software
// - Writing either count byte clears the prescaler
// - Oscillator enable starts crystal oscillator, which runs in sleep
// - Sync disable keeps the synchroniser; it only lets external counting run in sleep
// - Async external counting continues in sleep; overflow wakes the core
// - Mode switch neither loses nor adds an increment; both modes share one sampled path
// - Count byte reads while running always return a valid value
// - Gate polarity 0 counts while gate low, 1 while gate high
// - Gated counter increments while gate active, holds while inactive
// - Gate source: pin, companion overflow, comparator one or two
`timescale 1ns/1ps
`default_nettype none
module gtc_timer (
  input  wire logic                         clk_i,
  input  wire logic                         rst_i,
  input  wire logic                         wb_cyc_i,
  input  wire logic                         wb_stb_i,
  input  wire logic                         wb_we_i,
  input  wire logic [gtc_pkg::GTC_ADDR_W-1:0] wb_adr_i,
  input  wire logic [3:0]                   wb_sel_i,
  input  wire logic [31:0]                  wb_dat_i,
  output logic      [31:0]                  wb_dat_o,
  output logic                              wb_ack_o,
  input  wire logic                         ext_clock_pin_i,
  input  wire logic                         cap_osc_i,
  input  wire logic                         crystal_in_pin_i,
  input  wire logic                         gate_pin_i,
  input  wire logic                         companion_ovf_i,
  input  wire logic                         cmp_one_out_synced_i,
  input  wire logic                         cmp_two_out_synced_i,
  input  wire logic                         sleep_i,
  output logic                              crystal_out_pin_o,
  output logic                              wake_o
);
  import gtc_pkg::*;

  // ****************************************
  // Pin synchronisers
  // ****************************************
  // Bit order: 0 ext pin, 1 cap osc, 2 crystal, 3 gate pin
  logic [3:0] sync1_ff, sync2_ff, sync3_ff, pin_ff, pin_prev_ff;
  wire  [3:0] pin_raw = {gate_pin_i, crystal_in_pin_i, cap_osc_i, ext_clock_pin_i};
  wire  [3:0] nxt_pin = (sync2_ff & sync3_ff) | (pin_ff & (sync2_ff | sync3_ff));

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1_ff    <= 4'h0;
      sync2_ff    <= 4'h0;
      sync3_ff    <= 4'h0;
      pin_ff      <= 4'h0;
      pin_prev_ff <= 4'h0;
    end else begin
      sync1_ff    <= pin_raw;
      sync2_ff    <= sync1_ff;
      sync3_ff    <= sync2_ff;
      pin_ff      <= nxt_pin;
      pin_prev_ff <= pin_ff;
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  gtc_ctrl_t   ctrl_ff;
  gtc_gate_t   gate_ff;
  logic [15:0] count_ff;
  logic [2:0]  pre_ff;
  logic [1:0]  phase_ff;
  logic        armed_ff, ovf_ff, on_prev_ff;

  wire req      = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wr       = req & wb_we_i & wb_sel_i[0];
  wire wr_low   = wr & (wb_adr_i == GTC_OFS_COUNT_LOW);
  wire wr_high  = wr & (wb_adr_i == GTC_OFS_COUNT_HIGH);
  wire wr_ctrl  = wr & (wb_adr_i == GTC_OFS_CTRL);
  wire wr_gate  = wr & (wb_adr_i == GTC_OFS_GATE);
  wire wr_stat  = wr & (wb_adr_i == GTC_OFS_STATUS);
  wire wr_count = wr_low | wr_high;

  // ****************************************
  // Counting clock selection
  // ****************************************
  wire is_ext    = ctrl_ff.clock_select[1];
  wire src_idx_c = (ctrl_ff.clock_select == GTC_CS_CAP);
  wire src_idx_x = ctrl_ff.crystal_osc_enable;
  wire src_lvl   = src_idx_c ? pin_ff[1] : (src_idx_x ? pin_ff[2] : pin_ff[0]);
  wire src_prev  = src_idx_c ? pin_prev_ff[1] : (src_idx_x ? pin_prev_ff[2] : pin_prev_ff[0]);
  wire src_rise  = src_lvl & ~src_prev;
  wire src_fall  = ~src_lvl & src_prev;

  // Core clocks stop in sleep; only an unsynchronised external source runs on
  // Both modes share one sampled path, so a mode switch never skips a count
  wire async_ext = is_ext & ctrl_ff.sync_disable;
  wire run_ok    = ~sleep_i | async_ext;

  logic tick;
  always_comb begin
    case (ctrl_ff.clock_select)
      GTC_CS_SYS:   tick = 1'b1;
      GTC_CS_INSTR: tick = (phase_ff == GTC_INSTR_DIV_M);
      GTC_CS_EXT:   tick = src_rise & armed_ff;
      GTC_CS_CAP:   tick = src_rise & armed_ff;
      default:      tick = 1'b0;
    endcase
  end

  // ****************************************
  // Gate and enable
  // ****************************************
  logic gate_sig;
  always_comb begin
    case (gate_ff.gate_source_select)
      GTC_GS_PIN:  gate_sig = pin_ff[3];
      GTC_GS_OVF:  gate_sig = companion_ovf_i;
      GTC_GS_CMP1: gate_sig = cmp_one_out_synced_i;
      GTC_GS_CMP2: gate_sig = cmp_two_out_synced_i;
      default:     gate_sig = 1'b0;
    endcase
  end

  wire gate_active = ~(gate_sig ^ gate_ff.gate_polarity);
  wire count_en    = ctrl_ff.counter_on & (~gate_ff.gate_control_enable | gate_active);
  wire pre_tick    = tick & count_en & run_ok;

  function automatic logic [2:0] pre_mask(input logic [1:0] sel);
    pre_mask = 3'((1 << sel) - 1);
  endfunction

  wire [2:0] mask    = pre_mask(ctrl_ff.prescale_select);
  wire       inc     = pre_tick & ((pre_ff & mask) == mask);
  wire       wrap    = inc & (count_ff == 16'hffff);
  wire [15:0] nxt_count_inc = count_ff + 16'h0001;

  // ****************************************
  // Counter, prescaler and arming
  // ****************************************
  logic [15:0] nxt_count;
  always_comb begin
    nxt_count = inc ? nxt_count_inc : count_ff;
    // A write wins over a concurrent increment; software should stop first
    if (wr_low)  nxt_count = {count_ff[15:8], wb_dat_i[7:0]};
    if (wr_high) nxt_count = {wb_dat_i[7:0], count_ff[7:0]};
  end

  wire [2:0] nxt_pre   = wr_count ? 3'h0 : (pre_tick ? ((pre_ff & mask) == mask ? 3'h0 :
                                             3'(pre_ff + 3'h1)) : pre_ff);
  wire       disarm    = wr_count | ~ctrl_ff.counter_on | (ctrl_ff.counter_on & ~on_prev_ff);
  wire       nxt_armed = disarm ? 1'b0 : (armed_ff | src_fall);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_ff   <= GTC_COUNT_RST;
      pre_ff     <= 3'h0;
      phase_ff   <= 2'h0;
      armed_ff   <= 1'b0;
      on_prev_ff <= 1'b0;
      ovf_ff     <= 1'b0;
      ctrl_ff    <= GTC_CTRL_RST;
      gate_ff    <= GTC_GATE_RST;
    end else begin
      count_ff   <= nxt_count;
      pre_ff     <= nxt_pre;
      phase_ff   <= sleep_i ? phase_ff : 2'(phase_ff + 2'h1);
      armed_ff   <= nxt_armed;
      on_prev_ff <= ctrl_ff.counter_on;
      // Set wins over a write-one clear in the same cycle
      ovf_ff     <= wrap | (ovf_ff & ~(wr_stat & wb_dat_i[GTC_STAT_OVF_BIT]));
      // Bit 1 is unused and always reads zero
      if (wr_ctrl) ctrl_ff <= gtc_ctrl_t'(wb_dat_i[7:0] & 8'hfd);
      if (wr_gate) gate_ff <= gtc_gate_t'({wb_dat_i[7:6], wb_dat_i[1:0]});
    end
  end

  // ****************************************
  // Bus answer and pin outputs
  // ****************************************
  logic [7:0] rd_byte;
  always_comb begin
    case (wb_adr_i)
      GTC_OFS_COUNT_LOW:  rd_byte = count_ff[7:0];
      GTC_OFS_COUNT_HIGH: rd_byte = count_ff[15:8];
      GTC_OFS_CTRL:       rd_byte = 8'(ctrl_ff);
      GTC_OFS_GATE:       rd_byte = {gate_ff[3:2], 4'h0, gate_ff[1:0]};
      GTC_OFS_STATUS:     rd_byte = {6'h00, ctrl_ff.crystal_osc_enable, ovf_ff};
      default:            rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o          <= 1'b0;
      wb_dat_o          <= 32'h0000_0000;
      crystal_out_pin_o <= 1'b0;
      wake_o            <= 1'b0;
    end else begin
      wb_ack_o          <= req;
      wb_dat_o          <= req ? {24'h00_0000, rd_byte} : 32'h0000_0000;
      // Amplifier runs regardless of sleep once enabled
      crystal_out_pin_o <= ctrl_ff.crystal_osc_enable & ~pin_ff[2];
      wake_o            <= wrap & sleep_i;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  off_holds_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (!ctrl_ff.counter_on && !wr_count) |=> count_ff == $past(count_ff))
    else $error("count moved while off");
  gate_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (gate_ff.gate_control_enable && !gate_active && !wr_count) |=> $stable(count_ff))
    else $error("count moved with gate inactive");
  sys_four_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (ctrl_ff.clock_select == GTC_CS_SYS && ctrl_ff.prescale_select == 2'h0 && count_en
     && !sleep_i && !wr_count && !wr_ctrl && !wr_gate) [*4] |=>
     count_ff == 16'($past(count_ff, 4) + 16'h0004))
    else $error("system clock not four per instruction");
  wr_clr_pre_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_count |=> pre_ff == 3'h0)
    else $error("prescaler not cleared by count write");
  wr_load_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_low |=> count_ff[7:0] == $past(wb_dat_i[7:0]))
    else $error("low byte not loaded");
  arm_first_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (is_ext && !armed_ff && !wr_count) |=> count_ff == $past(count_ff))
    else $error("external count before falling edge");
  pre_div_a: assert property (@(posedge clk_i) disable iff (rst_i)
    inc |-> (ctrl_ff.prescale_select == 2'h0 || pre_ff[0])
      && (ctrl_ff.prescale_select < 2'h2 || pre_ff[1])
      && (ctrl_ff.prescale_select != 2'h3 || pre_ff[2]))
    else $error("increment before prescale complete");
  wrap_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (wrap && !wr_count) |=> ovf_ff && count_ff == 16'h0000)
    else $error("wrap did not set overflow");
  sleep_stop_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (sleep_i && !async_ext && !wr_count) |=> $stable(count_ff))
    else $error("synchronous count ran in sleep");
  gate_sel_a: assert property (@(posedge clk_i) disable iff (rst_i)
    gate_ff.gate_source_select == GTC_GS_CMP2 |-> gate_sig == cmp_two_out_synced_i)
    else $error("gate source mismatch");
  wr_high_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_high |=> count_ff[15:8] == $past(wb_dat_i[7:0]))
    else $error("high byte not loaded");
  free_count_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (ctrl_ff.counter_on && !gate_ff.gate_control_enable && ctrl_ff.clock_select == GTC_CS_SYS
     && ctrl_ff.prescale_select == 2'h0 && !sleep_i && !wr_count)
     |=> count_ff == 16'($past(count_ff) + 16'h0001))
    else $error("free running count stalled");
  gate_count_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (ctrl_ff.counter_on && gate_ff.gate_control_enable && ctrl_ff.clock_select == GTC_CS_SYS
     && gate_ff.gate_source_select == GTC_GS_CMP1 && ctrl_ff.prescale_select == 2'h0
     && cmp_one_out_synced_i == gate_ff.gate_polarity && !sleep_i && !wr_count)
     |=> count_ff == 16'($past(count_ff) + 16'h0001))
    else $error("active gate did not count");
  instr_div_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (ctrl_ff.clock_select == GTC_CS_INSTR && ctrl_ff.prescale_select == 2'h0 && count_en
     && !sleep_i && !wr_count && !wr_ctrl && !wr_gate) [*4] |=>
     count_ff == 16'($past(count_ff, 4) + 16'h0001))
    else $error("instruction clock not one per four");
  ovf_sticky_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (ovf_ff && !(wr_stat && wb_dat_i[GTC_STAT_OVF_BIT])) |=> ovf_ff)
    else $error("overflow flag lost");
  ovf_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr_stat && wb_dat_i[GTC_STAT_OVF_BIT] && !wrap) |=> !ovf_ff)
    else $error("overflow flag not cleared");
  wake_sleep_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (wrap && sleep_i) |=> wake_o)
    else $error("overflow in sleep gave no wake");
  phase_sleep_a: assert property (@(posedge clk_i) disable iff (rst_i)
    sleep_i |=> $stable(phase_ff))
    else $error("instruction phase ran in sleep");
  arm_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_count |=> !armed_ff)
    else $error("count write left counter armed");
  osc_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !ctrl_ff.crystal_osc_enable |=> !crystal_out_pin_o)
    else $error("amplifier driven while disabled");
  reset_clear_a: assert property (@(posedge clk_i)
    rst_i |=> count_ff == GTC_COUNT_RST && pre_ff == 3'h0 && ctrl_ff == GTC_CTRL_RST
      && gate_ff == GTC_GATE_RST && !ovf_ff && !wb_ack_o)
    else $error("reset left state behind");

  // ****************************************
  // Bus checks
  // ****************************************
  ack_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  rd_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !wb_ack_o |-> wb_dat_o == 32'h0000_0000)
    else $error("read data outside ack cycle");
endmodule : gtc_timer
`default_nettype wire

// ==== bench/gtc_pins.sv ====
/*
  Far-side model: external clock pin pulses and a delayed crystal loop.
  Assumes the caller invokes pulses() from the bench's clocked sequence.
*/
`timescale 1ns/1ps
`default_nettype none
module gtc_pins (
  input  wire logic clk_i,
  input  wire logic crystal_out_pin_i,
  output logic      ext_clk_o,
  output logic      crystal_in_o
);
  logic [7:0] dly_ff = 8'h00;
  initial ext_clk_o = 1'b0;
  // Crystal modelled as a delay line, so the amplifier loop oscillates
  always @(posedge clk_i) dly_ff <= {dly_ff[6:0], crystal_out_pin_i};
  assign crystal_in_o = dly_ff[7];
  // Slow pulses so the pin filter sees every edge; idle level low
  task pulses(input int n);
    repeat (n) begin
      repeat (8) @(posedge clk_i);
      ext_clk_o <= 1'b1;
      repeat (8) @(posedge clk_i);
      ext_clk_o <= 1'b0;
    end
  endtask : pulses
endmodule : gtc_pins
`default_nettype wire

// ==== bench/tb_gtc_timer.sv ====
/*
  Testbench for the gated timer: Wishbone tasks and checked sequences.
  Assumes the design answers each request with a one-cycle ack.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_gtc_timer;
  import gtc_pkg::*;
  logic        clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, sleep = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0, rdat;
  logic [3:0]  gsig = 4'h0, sel = 4'h0;
  logic        ack, ext, xin, xout, wake;
  logic [15:0] c;
  logic [7:0]  t [4] = '{8'h41, 8'h51, 8'h71, 8'h01};
  int          e [4] = '{66, 33, 8, 16};
  int          n_errors = 0, num_checks = 0, n_wake = 0;
  always #10 clk_i = ~clk_i;
  always @(posedge clk_i) if (wake === 1'b1) n_wake <= n_wake + 1;
  gtc_pins u_gtc_pins (.clk_i(clk_i), .crystal_out_pin_i(xout), .ext_clk_o(ext),
    .crystal_in_o(xin));
  gtc_timer u_gtc_timer (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .ext_clock_pin_i(ext), .cap_osc_i(ext), .crystal_in_pin_i(xin),
    .gate_pin_i(gsig[0]), .companion_ovf_i(gsig[1]), .cmp_one_out_synced_i(gsig[2]),
    .cmp_two_out_synced_i(gsig[3]), .sleep_i(sleep), .crystal_out_pin_o(xout),
    .wake_o(wake));
  // ****************************************
  // Tasks
  // ****************************************
  task finish_test;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : finish_test
  task chk(input string nm, input logic [15:0] x, input logic [15:0] g);
    num_checks++;
    if (g !== x) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, x, g);
    end
  endtask : chk
  task rng(input string nm, input int lo, input int hi, input logic [15:0] g);
    num_checks++;
    if ((g >= lo && g <= hi) !== 1'b1) begin
      n_errors++;
      $display("wrong value %s expected %0d..%0d seen %0d", nm, lo, hi, g);
    end
  endtask : rng
  task xfer(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    int i;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= 4'h1;
    adr <= a;
    wdat <= {24'h0, d};
    i = 0;
    do begin
      @(posedge clk_i);
      i++;
    end while (ack !== 1'b1 && i < 20);
    if (ack !== 1'b1) begin
      n_errors++;
      $display("wrong value ack expected 1 seen 0");
      finish_test();
    end else begin
      q = rdat[7:0];
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      sel <= 4'h0;
    end
  endtask : xfer
  task wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    xfer(1'b1, a, d, q);
  endtask : wr
  task rdc(input string nm, input logic [7:0] a, input logic [7:0] x);
    logic [7:0] q;
    xfer(1'b0, a, 8'h00, q);
    chk(nm, {8'h0, x}, {8'h0, q});
  endtask : rdc
  task cnt(output logic [15:0] v);
    xfer(1'b0, GTC_OFS_COUNT_LOW, 8'h00, v[7:0]);
    xfer(1'b0, GTC_OFS_COUNT_HIGH, 8'h00, v[15:8]);
  endtask : cnt
  task ld(input logic [15:0] v);
    wr(GTC_OFS_COUNT_LOW, v[7:0]);
    wr(GTC_OFS_COUNT_HIGH, v[15:8]);
  endtask : ld
  // Counter is always stopped again before any count write
  task run(input logic [7:0] ctl, input int n);
    wr(GTC_OFS_CTRL, ctl);
    repeat (n) @(posedge clk_i);
    wr(GTC_OFS_CTRL, 8'h00);
    cnt(c);
  endtask : run
  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int a = 0; a < 6; a++) rdc("reset", 8'(a * 4), 8'h00);
    ld(16'ha55a);
    cnt(c);
    chk("count", 16'ha55a, c);
    $display("test reset and load done");
    for (int k = 0; k < 4; k++) begin
      ld(16'h0000);
      run(t[k], 64);
      rng("rate", e[k] - 2, e[k] + 3, c);
    end
    wr(GTC_OFS_GATE, 8'h80);
    ld(16'h0000);
    run(8'h40, 64);
    chk("off", 16'h0000, c);
    $display("test clocks done");
    for (int s = 0; s < 4; s++)
      for (int p = 0; p < 2; p++) begin
        gsig <= {4{~p[0]}};
        wr(GTC_OFS_GATE, {1'b1, p[0], 4'h0, 2'(s)});
        ld(16'h0000);
        repeat (8) @(posedge clk_i);
        run(8'h41, 64);
        chk("gate hold", 16'h0000, c);
        gsig[s] <= p[0];
        repeat (8) @(posedge clk_i);
        run(8'h41, 64);
        rng("gate count", 64, 69, c);
      end
    $display("test gate done");
    wr(GTC_OFS_GATE, 8'h00);
    ld(16'hfff0);
    run(8'h41, 64);
    rng("wrap", 48, 53, c);
    rdc("ovf set", GTC_OFS_STATUS, 8'h01);
    wr(GTC_OFS_STATUS, 8'h01);
    rdc("ovf clr", GTC_OFS_STATUS, 8'h00);
    for (int k = 0; k < 2; k++) begin
      ld(16'h0000);
      wr(GTC_OFS_CTRL, k ? 8'hc1 : 8'h81);
      u_gtc_pins.pulses(4);
      u_gtc_pins.pulses(2);
      repeat (8) @(posedge clk_i);
      wr(GTC_OFS_CTRL, 8'h00);
      cnt(c);
      chk("ext", 16'h0005, c);
    end
    wr(GTC_OFS_CTRL, 8'h08);
    rdc("osc", GTC_OFS_STATUS, 8'h02);
    repeat (50) @(posedge clk_i); // Start-up wait before use
    ld(16'h0000);
    run(8'h89, 200);
    rng("crystal", 3, 12, c);
    $display("test ext and crystal done");
    sleep <= 1'b1;
    ld(16'h0000);
    run(8'h41, 64);
    chk("sleep sync", 16'h0000, c);
    ld(16'hffff);
    wr(GTC_OFS_CTRL, 8'h85);
    u_gtc_pins.pulses(3);
    repeat (8) @(posedge clk_i);
    wr(GTC_OFS_CTRL, 8'h00);
    cnt(c);
    chk("sleep async", 16'h0001, c);
    chk("wake", 16'h0001, 16'(n_wake));
    $display("test sleep done");
    finish_test();
  end
endmodule : tb_gtc_timer
`default_nettype wire
